/* File: design/sosc_params.svh */
`ifndef SOSC_PARAMS_SVH
`define SOSC_PARAMS_SVH

`define SOSC_NUM_CTRL       2
`define SOSC_NUM_PAIRS      2
`define SOSC_NUM_UIO        4
`define SOSC_CLK_PERIOD_NS  8
`define SOSC_MS_TIME_NS     1000000
`define SOSC_MS_CYCLES      (`SOSC_MS_TIME_NS / `SOSC_CLK_PERIOD_NS)
`define SOSC_GRACE_TIME_S   1
`define SOSC_GRACE_MS       (`SOSC_GRACE_TIME_S * 1000)
`define SOSC_FN_IN_RESET    2'h0
`define SOSC_FN_IN_CFM      2'h1
`define SOSC_FN_IN_SLEEP    2'h2
`define SOSC_FN_IN_RESTART  2'h3
`define SOSC_FN_OUT_RST_REQ 2'h0
`define SOSC_FN_OUT_CONTAM  2'h1
`define SOSC_RST_LOCK       1'b1

`endif

/* File: design/sosc_pkg.sv */
`include "sosc_params.svh"

package sosc_pkg;

    typedef struct packed {
        logic                              restart_lock_en;
        logic                              seq_mon_en;
        logic                              uio_ctrl_pair;
        logic [15:0]                       switch_on_delay_ms;
        logic [`SOSC_NUM_UIO-1:0]          uio_is_out;
        logic [`SOSC_NUM_UIO-1:0][1:0]     uio_func;
    } sosc_cfg_t;

    typedef struct packed {
        logic device_error;
        logic pattern_error;
        logic restart_needed;
        logic sleep;
        logic contactor_feedback_monitor;
    } sosc_stat_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_DELAY = 2'b01,
        ST_GRACE = 2'b10,
        ST_LOCK  = 2'b11
    } sosc_state_t;

endpackage : sosc_pkg

/* File: design/sosc_top.sv */
`timescale 1ns/100ps
`include "sosc_params.svh"

// What this block does
// - safety outputs high when field clear and no device error
// - safety outputs low when field occupied or device error
// - control input is two channels: 10 gives 0, 01 gives 1, equal is error
// - non-complementary pattern forces all safety outputs off and flags device error
// - previous monitoring case stays active until switch-on delay expires
// - no sequence monitoring: invalid at delay end turns outputs off
// - no sequence monitoring: valid pattern within one second activates new case
// - no sequence monitoring: no valid pattern in that second locks with error
// - sequence monitoring: invalid at delay end turns off, errors, needs restart
// - each output pair has own restart interlock, enabled for all pairs by one setting, and own reset button
// - with interlock, output goes off as soon as field is interrupted
// - with interlock, output stays off after field clears until reset
// - latched interlock releases only on reset press with field clear
// - reset press while field occupied is ignored, output stays off
// - reset accepted only while all safety functions are operational
// - each universal pin configurable as input or output
// - universal input serves reset, feedback monitor, sleep or restart
// - two universal inputs can pair as one complementary control input
// - universal output carries status only, reset required or contamination
module sosc_top #(
    parameter int          NUM_CTRL  = `SOSC_NUM_CTRL,
    parameter int          NUM_PAIRS = `SOSC_NUM_PAIRS,
    parameter int unsigned MS_CYCLES = `SOSC_MS_CYCLES
) (
    input  wire logic                       i_clock,
    input  wire logic                       i_reset,
    input  wire logic [NUM_CTRL-1:0]        i_control_chan_one,
    input  wire logic [NUM_CTRL-1:0]        i_control_chan_two,
    input  wire logic [NUM_PAIRS-1:0]       i_field_clear,
    input  wire logic                       i_device_fault,
    input  wire logic                       i_contamination_warn,
    input  wire sosc_pkg::sosc_cfg_t        i_cfg,
    input  wire logic [`SOSC_NUM_UIO-1:0]   i_uio_pin,
    output logic      [`SOSC_NUM_UIO-1:0]   o_uio_pin,
    output logic      [`SOSC_NUM_UIO-1:0]   o_uio_oe_n,
    output logic      [2*NUM_PAIRS-1:0]     o_safety_switch_output,
    output logic      [NUM_PAIRS-1:0]       o_reset_required,
    output logic      [NUM_CTRL:0]          o_active_case,
    output sosc_pkg::sosc_stat_t            o_status
);
    import sosc_pkg::*;

    localparam int NU  = `SOSC_NUM_UIO;
    localparam int NC  = NUM_CTRL + 1;
    localparam int W   = 2 * NUM_CTRL + NU;
    localparam int MSW = $clog2(MS_CYCLES);

    // {error, value}: value follows channel two
    function automatic logic [1:0] sosc_decode(input logic a, input logic b);
        return {a == b, b};
    endfunction : sosc_decode

    // input synchroniser and agreement filter
    logic [W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
    logic [W-1:0] filt_next;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            filt_reg   <= '0;
            filt_d_reg <= '0;
        end else begin
            s1_reg     <= {i_uio_pin, i_control_chan_two, i_control_chan_one};
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            filt_reg   <= filt_next;
            filt_d_reg <= filt_reg;
        end
    end

    // control pattern decode and universal input functions
    logic [NU-1:0]        uio_lvl, uio_rise;
    logic                 pair_en, pattern_err, restart_evt, sleep_lvl, cfm_lvl;
    logic [NC-1:0]        ch_one, ch_two, pattern;
    logic [NUM_PAIRS-1:0] press;

    assign uio_lvl  = filt_reg[W-1 -: NU];
    assign uio_rise = filt_reg[W-1 -: NU] & ~filt_d_reg[W-1 -: NU];
    assign pair_en  = i_cfg.uio_ctrl_pair & ~i_cfg.uio_is_out[0] & ~i_cfg.uio_is_out[1];

    always_comb begin
        logic [1:0] dec;
        dec         = 2'h0;
        ch_one      = {pair_en ? uio_lvl[0] : 1'b1, filt_reg[NUM_CTRL-1:0]};
        ch_two      = {pair_en ? uio_lvl[1] : 1'b0, filt_reg[2*NUM_CTRL-1:NUM_CTRL]};
        pattern_err = 1'b0;
        pattern     = '0;
        for (int i = 0; i < NC; i++) begin
            dec         = sosc_decode(ch_one[i], ch_two[i]);
            pattern_err = pattern_err | dec[1];
            pattern[i]  = dec[0];
        end
        press       = '0;
        restart_evt = 1'b0;
        sleep_lvl   = 1'b0;
        cfm_lvl     = 1'b0;
        for (int i = 0; i < NU; i++) begin
            if (!i_cfg.uio_is_out[i] && !(pair_en && i < 2)) begin
                unique case (i_cfg.uio_func[i])
                    `SOSC_FN_IN_RESET:   press[i % NUM_PAIRS] = press[i % NUM_PAIRS] | uio_rise[i];
                    `SOSC_FN_IN_CFM:     cfm_lvl = cfm_lvl | uio_lvl[i];
                    `SOSC_FN_IN_SLEEP:   sleep_lvl = sleep_lvl | uio_lvl[i];
                    `SOSC_FN_IN_RESTART: restart_evt = restart_evt | uio_rise[i];
                endcase
            end
        end
    end

    // millisecond tick
    logic [MSW-1:0] ms_cnt_reg, ms_cnt_next;
    logic           ms_tick;

    assign ms_tick = (ms_cnt_reg == MSW'(MS_CYCLES - 1));

    always_comb begin
        ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
    end

    // monitoring case switching
    sosc_state_t   state_reg, state_next;
    logic [15:0]   tmr_reg, tmr_next;
    logic [NC:0]   last_reg, last_next;
    logic [NC-1:0] case_reg, case_next;
    logic          changed, expired, dev_err;

    assign changed = ({pattern_err, pattern} != last_reg);
    assign expired = (tmr_reg == 16'h0);
    assign dev_err = (state_reg == ST_GRACE) || (state_reg == ST_LOCK) || i_device_fault;

    always_comb begin
        state_next = state_reg;
        case_next  = case_reg;
        last_next  = {pattern_err, pattern};
        tmr_next   = (ms_tick && !expired) ? tmr_reg - 16'h1 : tmr_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (changed) begin
                    state_next = ST_DELAY;
                    tmr_next   = i_cfg.switch_on_delay_ms;
                end
            end
            ST_DELAY: begin
                if (changed) begin
                    tmr_next = i_cfg.switch_on_delay_ms;
                end else if (expired) begin
                    if (!pattern_err) begin
                        state_next = ST_RUN;
                        case_next  = pattern;
                    end else if (i_cfg.seq_mon_en) begin
                        state_next = ST_LOCK;
                    end else begin
                        state_next = ST_GRACE;
                        tmr_next   = 16'(`SOSC_GRACE_MS);
                    end
                end
            end
            ST_GRACE: begin
                if (!pattern_err) begin
                    state_next = ST_RUN;
                    case_next  = pattern;
                end else if (expired) begin
                    state_next = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (restart_evt && !pattern_err && !i_device_fault) begin
                    state_next = ST_RUN;
                    case_next  = pattern;
                end
            end
        endcase
    end

    // restart interlock per pair and outputs
    logic [NUM_PAIRS-1:0]   lock_reg, lock_next, ok, on_next, rr_next;
    logic [2*NUM_PAIRS-1:0] ssw_reg, ssw_next;
    logic [NUM_PAIRS-1:0]   rr_reg;
    logic [NU-1:0]          uo_reg, uo_next, oe_n_reg, oe_n_next;
    sosc_stat_t             stat_reg, stat_next;

    always_comb begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
            ok[p]        = i_field_clear[p] && !dev_err;
            lock_next[p] = lock_reg[p];
            if (press[p] && ok[p]) begin
                lock_next[p] = 1'b0;
            end
            if (!ok[p]) begin
                lock_next[p] = 1'b1;
            end
            if (!i_cfg.restart_lock_en) begin
                lock_next[p] = 1'b0;
            end
            on_next[p]          = ok[p] && !(i_cfg.restart_lock_en && lock_reg[p]);
            ssw_next[2*p]       = on_next[p];
            ssw_next[2*p+1]     = on_next[p];
            rr_next[p]          = i_cfg.restart_lock_en && lock_reg[p] && i_field_clear[p];
        end
        for (int i = 0; i < NU; i++) begin
            oe_n_next[i] = !i_cfg.uio_is_out[i];
            unique case (i_cfg.uio_func[i])
                `SOSC_FN_OUT_RST_REQ: uo_next[i] = i_cfg.uio_is_out[i] && rr_reg[i % NUM_PAIRS];
                `SOSC_FN_OUT_CONTAM:  uo_next[i] = i_cfg.uio_is_out[i] && i_contamination_warn;
                default:              uo_next[i] = 1'b0;
            endcase
        end
        stat_next = '{device_error: dev_err, pattern_error: pattern_err,
                      restart_needed: (state_reg == ST_LOCK), sleep: sleep_lvl,
                      contactor_feedback_monitor: cfm_lvl};
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ms_cnt_reg <= '0;
            state_reg  <= ST_GRACE;
            tmr_reg    <= 16'(`SOSC_GRACE_MS);
            last_reg   <= '0;
            case_reg   <= '0;
            lock_reg   <= {NUM_PAIRS{`SOSC_RST_LOCK}};
            ssw_reg    <= '0;
            rr_reg     <= '0;
            uo_reg     <= '0;
            oe_n_reg   <= '1;
            stat_reg   <= '0;
        end else begin
            ms_cnt_reg <= ms_cnt_next;
            state_reg  <= state_next;
            tmr_reg    <= tmr_next;
            last_reg   <= last_next;
            case_reg   <= case_next;
            lock_reg   <= lock_next;
            ssw_reg    <= ssw_next;
            rr_reg     <= rr_next;
            uo_reg     <= uo_next;
            oe_n_reg   <= oe_n_next;
            stat_reg   <= stat_next;
        end
    end

    assign o_safety_switch_output = ssw_reg;
    assign o_reset_required       = rr_reg;
    assign o_active_case          = case_reg;
    assign o_uio_pin              = uo_reg;
    assign o_uio_oe_n             = oe_n_reg;
    assign o_status               = stat_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence seq_bad_end;
        state_reg == ST_DELAY && !changed && expired && pattern_err;
    endsequence

    chk_field_off:    assert property (!i_field_clear[0] |=> !ssw_reg[0] && !ssw_reg[1])
        else $error("output on with field occupied");
    chk_field_on:     assert property (i_field_clear[0] && !dev_err && !i_cfg.restart_lock_en |=> ssw_reg[0])
        else $error("output off with field clear");
    chk_decode_equal: assert property (ch_one[0] == ch_two[0] |-> pattern_err)
        else $error("equal channels not flagged");
    chk_seq_lock:     assert property (seq_bad_end and i_cfg.seq_mon_en |=> state_reg == ST_LOCK ##1 !ssw_reg[0])
        else $error("sequence error did not lock");
    chk_grace_off:    assert property (seq_bad_end and !i_cfg.seq_mon_en |=> state_reg == ST_GRACE ##1 !ssw_reg[0])
        else $error("invalid pattern did not switch off");
    chk_grace_ok:     assert property (state_reg == ST_GRACE && !pattern_err |=> state_reg == ST_RUN && case_reg == $past(pattern))
        else $error("valid pattern not taken in grace");
    chk_grace_end:    assert property (state_reg == ST_GRACE && pattern_err && expired |=> state_reg == ST_LOCK)
        else $error("grace timeout did not lock");
    chk_delay_hold:   assert property (state_reg == ST_DELAY && !expired |=> $stable(case_reg))
        else $error("case changed before delay end");
    chk_lock_hold:    assert property (i_cfg.restart_lock_en && lock_reg[0] |=> !ssw_reg[0])
        else $error("output on while interlocked");
    chk_press_ignore: assert property (i_cfg.restart_lock_en && press[0] && !ok[0] |=> lock_reg[0])
        else $error("reset accepted while unsafe");
    chk_reset_req:    assert property (i_cfg.restart_lock_en && lock_reg[0] && i_field_clear[0] |=> rr_reg[0])
        else $error("reset required not shown");
    chk_lock_status:  assert property (state_reg == ST_LOCK |=> stat_reg.restart_needed)
        else $error("lock state not reported");
    chk_fault_error:  assert property (i_device_fault |=> stat_reg.device_error && !ssw_reg[0])
        else $error("fault not reported as device error");
    chk_uio_drive:    assert property (1'b1 |=> o_uio_oe_n == ~$past(i_cfg.uio_is_out))
        else $error("pin direction wrong");
    chk_uio_rst_req:  assert property (i_cfg.uio_is_out[0] && i_cfg.uio_func[0] == `SOSC_FN_OUT_RST_REQ |=> o_uio_pin[0] == $past(rr_reg[0]))
        else $error("reset required pin wrong");

endmodule : sosc_top

/* File: bench/sosc_machine_model.sv */
`timescale 1ns/100ps
module sosc_machine_model (
    input  wire logic [1:0] i_case,
    input  wire logic       i_bad,
    input  wire logic [2:0] i_button,
    input  wire logic [3:0] i_oe_n,
    input  wire logic [3:0] i_pin_out,
    output logic      [1:0] o_chan_one,
    output logic      [1:0] o_chan_two,
    output logic      [3:0] o_pin
);
    logic [3:0] btn;

    // two position switches per input; bad shorts input 1 high on both channels
    always_comb begin
        o_chan_one = ~i_case;
        o_chan_two = i_case;
        if (i_bad) begin
            o_chan_one[1] = 1'b1;
            o_chan_two[1] = 1'b1;
        end
    end

    // buttons drive reset, restart, paired control or status input pins, never start motion; pin 3 has no button and reads low as an input
    assign btn   = {1'b0, i_button};
    assign o_pin = (i_oe_n & btn) | (~i_oe_n & i_pin_out);
endmodule : sosc_machine_model

/* File: bench/tb_sosc_top.sv */
`timescale 1ns/100ps
`include "sosc_params.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb_sosc_top;
    import sosc_pkg::*;
    logic                i_clock, i_reset, i_device_fault, i_contamination_warn, bad, smp;
    logic [1:0]          field, case_sel, chan_one, chan_two, rr;
    logic [2:0]          btn, act;
    logic [3:0]          pin_in, pin_out, oe_n, sout;
    logic [7:0]          rnd;
    sosc_cfg_t           cfg;
    sosc_stat_t          stat;
    logic [14:0]         exp_q[$];
    logic [14:0]         exp_v;
    sosc_stat_t          exp_sq[$];
    sosc_stat_t          exp_s;
    sosc_cfg_t           cfg_p;
    logic                smp_st;
    int                  n_fail = 0, compares = 0, cycles = 0;

    sosc_top #(.MS_CYCLES(10)) sosc_top_i (.i_clock(i_clock), .i_reset(i_reset),
        .i_control_chan_one(chan_one), .i_control_chan_two(chan_two), .i_field_clear(field),
        .i_device_fault(i_device_fault), .i_contamination_warn(i_contamination_warn), .i_cfg(cfg),
        .i_uio_pin(pin_in), .o_uio_pin(pin_out), .o_uio_oe_n(oe_n), .o_safety_switch_output(sout),
        .o_reset_required(rr), .o_active_case(act), .o_status(stat));
    sosc_machine_model sosc_machine_model_i (.i_case(case_sel), .i_bad(bad), .i_button(btn),
        .i_oe_n(oe_n), .i_pin_out(pin_out), .o_chan_one(chan_one), .o_chan_two(chan_two), .o_pin(pin_in));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic sosc_cfg_t mk_cfg(input logic lock, input logic seq, input logic [15:0] dly);
        sosc_cfg_t c;
        c = '0;
        c.restart_lock_en    = lock;
        c.seq_mon_en         = seq;
        c.switch_on_delay_ms = dly;
        c.uio_is_out         = 4'h8;
        c.uio_func           = {`SOSC_FN_OUT_CONTAM, `SOSC_FN_IN_RESTART, `SOSC_FN_IN_RESET, `SOSC_FN_IN_RESET};
        return c;
    endfunction : mk_cfg

    task automatic do_reset(input sosc_cfg_t c);
        cfg     <= c;
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
    endtask : do_reset

    // wait, then note the expected outputs and ask the monitor to compare
    task automatic chk(input int n, input logic [3:0] s, input logic [1:0] r, input logic e, input logic [2:0] a);
        rnd = lfsr_next(rnd);
        i_contamination_warn <= rnd[0];
        repeat (n) @(posedge i_clock);
        exp_q.push_back({s, r, e, a, 4'h7, rnd[0]});
        smp <= 1'b1;
        @(posedge i_clock);
        smp <= 1'b0;
    endtask : chk

    task automatic chk_st(input int n, input sosc_stat_t st);
        repeat (n) @(posedge i_clock);
        exp_sq.push_back(st);
        smp_st <= 1'b1;
        @(posedge i_clock);
        smp_st <= 1'b0;
    endtask : chk_st

    task automatic press(input int k);
        btn[k] <= 1'b1;
        repeat (8) @(posedge i_clock);
        btn[k] <= 1'b0;
        repeat (8) @(posedge i_clock);
    endtask : press

    always @(negedge i_clock) begin
        if (smp === 1'b1 && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK({sout, rr, stat.device_error, act, oe_n, pin_out[3]}, exp_v)
        end
        if (smp_st === 1'b1 && exp_sq.size() > 0) begin
            exp_s = exp_sq.pop_front();
            `CHK(stat, exp_s)
        end
    end

    task automatic end_of_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        {i_reset, i_device_fault, i_contamination_warn, bad, smp} = 5'h10;
        {field, case_sel, btn, rnd} = {2'h3, 2'h0, 3'h0, 8'h54};
        smp_st = 1'b0;
        cfg = mk_cfg(1'b0, 1'b0, 16'h2);
        do_reset(mk_cfg(1'b0, 1'b0, 16'h2));
        chk(60, 4'hf, 2'h0, 1'b0, 3'h0);
        field <= 2'h2;
        chk(4, 4'hc, 2'h0, 1'b0, 3'h0);
        field <= 2'h3;
        case_sel <= 2'h1;
        chk(12, 4'hf, 2'h0, 1'b0, 3'h0);
        chk(40, 4'hf, 2'h0, 1'b0, 3'h1);
        bad <= 1'b1;
        chk(60, 4'h0, 2'h0, 1'b1, 3'h1);
        bad <= 1'b0;
        case_sel <= 2'h2;
        chk(60, 4'hf, 2'h0, 1'b0, 3'h2);
        bad <= 1'b1;
        chk(10100, 4'h0, 2'h0, 1'b1, 3'h2);
        bad <= 1'b0;
        chk(60, 4'h0, 2'h0, 1'b1, 3'h2);
        press(2);
        chk(6, 4'hf, 2'h0, 1'b0, 3'h2);
        i_device_fault <= 1'b1;
        chk(4, 4'h0, 2'h0, 1'b1, 3'h2);
        i_device_fault <= 1'b0;
        chk(4, 4'hf, 2'h0, 1'b0, 3'h2);
        $display("done: case switching");
        do_reset(mk_cfg(1'b0, 1'b1, 16'h0));
        chk(30, 4'hf, 2'h0, 1'b0, 3'h2);
        bad <= 1'b1;
        chk(20, 4'h0, 2'h0, 1'b1, 3'h2);
        bad <= 1'b0;
        chk(20, 4'h0, 2'h0, 1'b1, 3'h2);
        press(2);
        chk(6, 4'hf, 2'h0, 1'b0, 3'h2);
        $display("done: sequence monitoring");
        do_reset(mk_cfg(1'b1, 1'b0, 16'h2));
        chk(60, 4'h0, 2'h3, 1'b0, 3'h2);
        field <= 2'h2;
        press(0);
        chk(4, 4'h0, 2'h2, 1'b0, 3'h2);
        field <= 2'h3;
        press(0);
        chk(4, 4'h3, 2'h2, 1'b0, 3'h2);
        press(1);
        chk(4, 4'hf, 2'h0, 1'b0, 3'h2);
        field <= 2'h1;
        chk(4, 4'h3, 2'h0, 1'b0, 3'h2);
        field <= 2'h3;
        chk(4, 4'h3, 2'h2, 1'b0, 3'h2);
        i_device_fault <= 1'b1;
        chk(4, 4'h0, 2'h3, 1'b1, 3'h2);
        press(0);
        i_device_fault <= 1'b0;
        chk(4, 4'h0, 2'h3, 1'b0, 3'h2);
        press(0);
        press(1);
        chk(4, 4'hf, 2'h0, 1'b0, 3'h2);
        $display("done: restart interlock");
        cfg_p = mk_cfg(1'b0, 1'b1, 16'h0);
        cfg_p.uio_ctrl_pair = 1'b1;
        btn <= 3'h2;
        do_reset(cfg_p);
        chk(60, 4'hf, 2'h0, 1'b0, 3'h6);
        btn <= 3'h3;
        chk_st(20, 5'h1c);
        btn <= 3'h1;
        repeat (8) @(posedge i_clock);
        press(2);
        chk(6, 4'hf, 2'h0, 1'b0, 3'h2);
        cfg_p = mk_cfg(1'b0, 1'b0, 16'h2);
        cfg_p.uio_func[0] = `SOSC_FN_IN_CFM;
        cfg_p.uio_func[1] = `SOSC_FN_IN_SLEEP;
        btn <= 3'h3;
        do_reset(cfg_p);
        chk_st(60, 5'h03);
        $display("done: universal inputs");
        repeat (2) @(posedge i_clock);
        end_of_test();
    end
endmodule : tb_sosc_top
